/* File: verilog/ops_pkg.sv */
// Constants for the output stage pulse and phase shaper.
package ops_pkg;

  // Register byte offsets on the APB bus.
  localparam logic [7:0] ADDR_DIVIDE     = 8'h00;
  localparam logic [7:0] ADDR_PULSE_HIGH = 8'h04;
  localparam logic [7:0] ADDR_EDGE_SHIFT = 8'h08;
  localparam logic [7:0] ADDR_CONTROL    = 8'h0C;
  localparam logic [7:0] ADDR_STATUS     = 8'h10;
  localparam logic [7:0] ADDR_BUF_BASE   = 8'h14;

  // Values after reset.
  localparam logic [31:0] RST_DIVIDE     = 32'h0000_0002;
  localparam logic [31:0] RST_PULSE_HIGH = 32'h0000_0000;
  localparam logic [11:0] RST_BUF_CFG    = 12'h000;

  // Buffer configuration field positions.
  localparam int BUF_SE_BIT     = 0;
  localparam int BUF_INV_BIT    = 1;
  localparam int BUF_SWING_LSB  = 2;
  localparam int BUF_CM_LSB     = 4;
  localparam int BUF_IMP_LSB    = 7;
  localparam int BUF_SUPPLY_LSB = 9;
  localparam int BUF_CFG_W      = 12;

  // Swing codes: 410 mV, 600 mV, 750 mV and 900 mV nominal.
  localparam logic [1:0] SWING_410MV = 2'h0;
  localparam logic [1:0] SWING_600MV = 2'h1;
  localparam logic [1:0] SWING_750MV = 2'h2;
  localparam logic [1:0] SWING_900MV = 2'h3;
  // Crossing level code n selects 0.9 V plus n times 0.2 V, up to 2.3 V.
  localparam logic [2:0] CM_0V9 = 3'h0;
  localparam logic [2:0] CM_2V3 = 3'h7;

  // Shortest high or low portion with and without a coarse shift, in synth cycles.
  localparam logic [33:0] MIN_ADJ_CYCLES  = 34'h0_0000_0002;
  localparam logic [33:0] MIN_BASE_CYCLES = 34'h0_0000_0001;

  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_HIGH = 2'b01,
    PH_LOW  = 2'b10
  } ops_phase_t;

endpackage : ops_pkg

/* File: verilog/ops_shaper.sv */
// Output stage pulse width and coarse phase shaper with APB registers.
//
// Contract
// - Divide synth clock by 32-bit integer ratio.
// - Zero pulse count gives even 50/50 split.
// - Nonzero pulse count sets high cycles.
// - Pulses always high-going; invert complement for low.
// - Per-output coarse shift by whole synth cycles; here one shift register serves all outputs.
// - Shift never leaves under two high, two low.
// - One shift moves each portion up to 2^32; here the signed 32-bit shift gives at most 2^31.
// - Positive lengthens, negative shortens, one period.
// - 50/50 outputs split shift between both portions.
// - Pulse outputs apply shift to low portion only.
// - Repeated shifts accepted without cumulative limit.
// - Each buffer differential or two single-ended.
// - Single-ended pins copy clock, optional complement invert.
// - Two-bit swing code selects four swings.
// - Three-bit code selects eight crossing levels.
// - Single-ended mode offers four impedance choices.
//
// Decided for this implementation: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`default_nettype none

module ops_shaper #(
  parameter int NUM_BUF = 2
) (
  // Clock and reset; CLOCK is the synthesizer clock.
  input  wire logic                   CLOCK,
  input  wire logic                   ARST_N,
  // APB slave.
  input  wire logic                   PSEL,
  input  wire logic                   PENABLE,
  input  wire logic                   PWRITE,
  input  wire logic [7:0]             PADDR,
  input  wire logic [31:0]            PWDATA,
  output logic      [31:0]            PRDATA,
  output logic                        PREADY,
  output logic                        PSLVERR,
  // Output pins.
  output logic      [NUM_BUF-1:0]     TRUE_OUTPUT_PIN,
  output logic      [NUM_BUF-1:0]     COMPLEMENT_OUTPUT_PIN,
  // Buffer settings toward the analog pads.
  output logic      [NUM_BUF-1:0]     SINGLE_ENDED,
  output logic      [2*NUM_BUF-1:0]   SWING_SELECT,
  output logic      [3*NUM_BUF-1:0]   COMMON_MODE_SELECT,
  output logic      [2*NUM_BUF-1:0]   IMPEDANCE_SELECT,
  output logic      [3*NUM_BUF-1:0]   SUPPLY_LEVEL_CODE
);

  logic [31:0]              divide_ff;
  logic [31:0]              pulse_high_ff;
  logic [31:0]              shift_ff;
  logic                     shift_pend_ff;
  logic                     run_ff;
  logic [ops_pkg::BUF_CFG_W-1:0] buf_cfg_ff [NUM_BUF];
  ops_pkg::ops_phase_t      phase_ff;
  logic [33:0]              cnt_ff;
  logic [33:0]              len_high_ff;
  logic [33:0]              len_low_ff;
  logic                     adj_used_ff;
  logic [31:0]              div_used_ff;
  logic [31:0]              pulse_used_ff;
  logic                     boundary;
  logic                     nxt_high;
  logic [33:0]              nxt_len_high;
  logic [33:0]              nxt_len_low;
  logic                     wr_acc;
  logic                     rd_acc;
  logic                     shift_wr;
  logic [31:0]              nxt_rdata;
  logic                     nxt_err;

  // Returns the buffer index an address hits, or NUM_BUF when none.
  function automatic int buf_index(input logic [7:0] addr);
    int idx;
    idx = NUM_BUF;
    for (int i = 0; i < NUM_BUF; i++) begin
      if (addr == ops_pkg::ADDR_BUF_BASE + 8'(4 * i)) begin
        idx = i;
      end
    end
    return idx;
  endfunction : buf_index

  // Clamps a signed length to a floor and narrows it.
  function automatic logic [33:0] clamp_len(input logic signed [35:0] v,
                                            input logic [33:0] floor_v);
    logic signed [35:0] f;
    f = signed'({2'b00, floor_v});
    return (v < f) ? floor_v : v[33:0];
  endfunction : clamp_len

  // APB access phase; the answer comes one cycle after access starts.
  assign wr_acc   = PSEL && PENABLE && !PREADY && PWRITE;
  assign rd_acc   = PSEL && PENABLE && !PREADY && !PWRITE;
  assign shift_wr = wr_acc && (PADDR == ops_pkg::ADDR_EDGE_SHIFT);

  always_comb begin
    nxt_rdata = 32'h0000_0000;
    nxt_err   = 1'b0;
    case (PADDR)
      ops_pkg::ADDR_DIVIDE:     nxt_rdata = divide_ff;
      ops_pkg::ADDR_PULSE_HIGH: nxt_rdata = pulse_high_ff;
      ops_pkg::ADDR_EDGE_SHIFT: nxt_rdata = shift_ff;
      ops_pkg::ADDR_CONTROL:    nxt_rdata = {31'h0000_0000, run_ff};
      ops_pkg::ADDR_STATUS:     nxt_rdata = {28'h000_0000, adj_used_ff,
                                  phase_ff, shift_pend_ff};
      default: begin
        if (buf_index(PADDR) < NUM_BUF) begin
          nxt_rdata = {20'h0_0000, buf_cfg_ff[buf_index(PADDR)]};
        end else begin
          nxt_err = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      PREADY  <= 1'b0;
      PRDATA  <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end else begin
      PREADY  <= PSEL && PENABLE && !PREADY;
      PRDATA  <= rd_acc ? nxt_rdata : 32'h0000_0000;
      PSLVERR <= (PSEL && PENABLE && !PREADY) ? nxt_err : 1'b0;
    end
  end

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      divide_ff     <= ops_pkg::RST_DIVIDE;
      pulse_high_ff <= ops_pkg::RST_PULSE_HIGH;
      run_ff        <= 1'b0;
    end else if (wr_acc) begin
      if (PADDR == ops_pkg::ADDR_DIVIDE) divide_ff <= PWDATA;
      if (PADDR == ops_pkg::ADDR_PULSE_HIGH) pulse_high_ff <= PWDATA;
      if (PADDR == ops_pkg::ADDR_CONTROL) run_ff <= PWDATA[0];
    end
  end

  // A write arms a shift; the boundary consumes it, but a write wins.
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      shift_ff      <= 32'h0000_0000;
      shift_pend_ff <= 1'b0;
    end else if (shift_wr) begin
      shift_ff      <= PWDATA;
      shift_pend_ff <= 1'b1;
    end else if (boundary) begin
      shift_pend_ff <= 1'b0;
    end
  end

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      for (int i = 0; i < NUM_BUF; i++) begin
        buf_cfg_ff[i] <= ops_pkg::RST_BUF_CFG;
      end
    end else if (wr_acc && buf_index(PADDR) < NUM_BUF) begin
      buf_cfg_ff[buf_index(PADDR)] <= PWDATA[ops_pkg::BUF_CFG_W-1:0];
    end
  end

  // Period lengths for the next period, from the settings held now.
  always_comb begin
    logic signed [35:0] div_s;
    logic signed [35:0] adj_s;
    logic signed [35:0] base_h;
    logic signed [35:0] base_l;
    logic signed [35:0] adj_h;
    logic signed [35:0] adj_l;
    base_h = 36'sh0_0000_0000;
    base_l = 36'sh0_0000_0000;
    adj_h  = 36'sh0_0000_0000;
    adj_l  = 36'sh0_0000_0000;
    div_s = signed'({4'h0, divide_ff});
    adj_s = signed'({{4{shift_ff[31]}}, shift_ff});
    if (pulse_high_ff == 32'h0000_0000) begin
      base_h = div_s - (div_s >>> 1);
      base_l = div_s >>> 1;
      adj_h  = adj_s >>> 1;
      adj_l  = adj_s - (adj_s >>> 1);
    end else begin
      base_h = signed'({4'h0, pulse_high_ff});
      base_l = div_s - signed'({4'h0, pulse_high_ff});
      adj_h  = 36'sh0_0000_0000;
      adj_l  = adj_s;
    end
    if (shift_pend_ff) begin
      nxt_len_high = clamp_len(base_h + adj_h,
                               ops_pkg::MIN_ADJ_CYCLES);
      nxt_len_low  = clamp_len(base_l + adj_l,
                               ops_pkg::MIN_ADJ_CYCLES);
    end else begin
      nxt_len_high = clamp_len(base_h, ops_pkg::MIN_BASE_CYCLES);
      nxt_len_low  = clamp_len(base_l, ops_pkg::MIN_BASE_CYCLES);
    end
  end

  assign boundary = run_ff && ((phase_ff == ops_pkg::PH_IDLE) ||
                    (phase_ff == ops_pkg::PH_LOW && cnt_ff == 34'h0));

  // Period sequencer: settings are latched only at a boundary.
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      phase_ff      <= ops_pkg::PH_IDLE;
      cnt_ff        <= 34'h0;
      len_high_ff   <= 34'h0;
      len_low_ff    <= 34'h0;
      adj_used_ff   <= 1'b0;
      div_used_ff   <= 32'h0000_0000;
      pulse_used_ff <= 32'h0000_0000;
    end else if (!run_ff) begin
      phase_ff <= ops_pkg::PH_IDLE;
      cnt_ff   <= 34'h0;
    end else if (boundary) begin
      phase_ff      <= ops_pkg::PH_HIGH;
      cnt_ff        <= nxt_len_high - 34'h1;
      len_high_ff   <= nxt_len_high;
      len_low_ff    <= nxt_len_low;
      adj_used_ff   <= shift_pend_ff;
      div_used_ff   <= divide_ff;
      pulse_used_ff <= pulse_high_ff;
    end else begin
      case (phase_ff)
        ops_pkg::PH_HIGH: begin
          if (cnt_ff == 34'h0) begin
            phase_ff <= ops_pkg::PH_LOW;
            cnt_ff   <= len_low_ff - 34'h1;
          end else begin
            cnt_ff <= cnt_ff - 34'h1;
          end
        end
        ops_pkg::PH_LOW: cnt_ff <= cnt_ff - 34'h1;
        default:         phase_ff <= ops_pkg::PH_IDLE;
      endcase
    end
  end

  // Output level that the sequencer enters this cycle.
  always_comb begin
    nxt_high = 1'b0;
    if (run_ff) begin
      if (boundary) begin
        nxt_high = 1'b1;
      end else if (phase_ff == ops_pkg::PH_HIGH) begin
        nxt_high = (cnt_ff != 34'h0);
      end
    end
  end

  // Pins and pad codes, all registered.
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      TRUE_OUTPUT_PIN       <= '0;
      COMPLEMENT_OUTPUT_PIN <= '0;
      SINGLE_ENDED          <= '0;
      SWING_SELECT          <= '0;
      COMMON_MODE_SELECT    <= '0;
      IMPEDANCE_SELECT      <= '0;
      SUPPLY_LEVEL_CODE     <= '0;
    end else begin
      for (int i = 0; i < NUM_BUF; i++) begin
        TRUE_OUTPUT_PIN[i] <= nxt_high;
        // Differential pairs always invert; single-ended copies may.
        COMPLEMENT_OUTPUT_PIN[i] <= nxt_high ^
          (!buf_cfg_ff[i][ops_pkg::BUF_SE_BIT] ||
           buf_cfg_ff[i][ops_pkg::BUF_INV_BIT]);
        SINGLE_ENDED[i] <= buf_cfg_ff[i][ops_pkg::BUF_SE_BIT];
        SWING_SELECT[2*i +: 2] <=
          buf_cfg_ff[i][ops_pkg::BUF_SWING_LSB +: 2];
        COMMON_MODE_SELECT[3*i +: 3] <=
          buf_cfg_ff[i][ops_pkg::BUF_CM_LSB +: 3];
        IMPEDANCE_SELECT[2*i +: 2] <=
          buf_cfg_ff[i][ops_pkg::BUF_IMP_LSB +: 2];
        SUPPLY_LEVEL_CODE[3*i +: 3] <=
          buf_cfg_ff[i][ops_pkg::BUF_SUPPLY_LSB +: 3];
      end
    end
  end

  // Checks.
  chk_settings_boundary: assert property (@(posedge CLOCK)
    disable iff (!ARST_N) $changed(len_high_ff) |-> $past(boundary))
    else $error("period lengths changed off a boundary");
  chk_adjust_minimum: assert property (@(posedge CLOCK)
    disable iff (!ARST_N) boundary && shift_pend_ff |=>
    len_high_ff >= 34'h2 && len_low_ff >= 34'h2)
    else $error("coarse shift left a portion under two");
  chk_even_split: assert property (@(posedge CLOCK)
    disable iff (!ARST_N) boundary && !shift_pend_ff &&
    pulse_high_ff == 32'h0 && divide_ff >= 32'h2 |=>
    len_high_ff + len_low_ff == {2'b00, div_used_ff} &&
    len_high_ff - len_low_ff <= 34'h1)
    else $error("default duty is not even");
  chk_pulse_width: assert property (@(posedge CLOCK)
    disable iff (!ARST_N) boundary && pulse_high_ff != 32'h0 |=>
    len_high_ff == {2'b00, pulse_used_ff} ||
    (adj_used_ff && pulse_used_ff == 32'h1 && len_high_ff == 34'h2))
    else $error("pulse high width wrong");
  chk_high_going: assert property (@(posedge CLOCK)
    disable iff (!ARST_N) boundary &&
    !(wr_acc && PADDR == ops_pkg::ADDR_CONTROL) |=> TRUE_OUTPUT_PIN[0]
    ##1 (TRUE_OUTPUT_PIN[0] == (len_high_ff > 34'h1)))
    else $error("period does not start high");
  chk_shift_consumed: assert property (@(posedge CLOCK)
    disable iff (!ARST_N) boundary && shift_pend_ff && !shift_wr |=>
    !shift_pend_ff && adj_used_ff)
    else $error("coarse shift not consumed at boundary");
  chk_diff_complement: assert property (@(posedge CLOCK)
    disable iff (!ARST_N) $past(ARST_N) &&
    !$past(buf_cfg_ff[0][ops_pkg::BUF_SE_BIT]) |->
    COMPLEMENT_OUTPUT_PIN[0] != TRUE_OUTPUT_PIN[0])
    else $error("differential complement not inverted");
  chk_se_copy: assert property (@(posedge CLOCK)
    disable iff (!ARST_N) $past(buf_cfg_ff[0][ops_pkg::BUF_SE_BIT]) |->
    (COMPLEMENT_OUTPUT_PIN[0] ^ TRUE_OUTPUT_PIN[0]) ==
    $past(buf_cfg_ff[0][ops_pkg::BUF_INV_BIT]))
    else $error("single-ended copy polarity wrong");
  chk_apb_answer: assert property (@(posedge CLOCK)
    disable iff (!ARST_N) PSEL && PENABLE && !PREADY |=> PREADY ##1 !PREADY)
    else $error("APB answer not one cycle later");

  cov_lengthen: cover property (@(posedge CLOCK) disable iff (!ARST_N)
    boundary && shift_pend_ff && !shift_ff[31]);
  cov_shorten: cover property (@(posedge CLOCK) disable iff (!ARST_N)
    boundary && shift_pend_ff && shift_ff[31]);
  cov_pulse_mode: cover property (@(posedge CLOCK) disable iff (!ARST_N)
    boundary && pulse_high_ff != 32'h0 ##1 TRUE_OUTPUT_PIN[0]);

endmodule : ops_shaper

`default_nettype wire

/* File: dv/ops_clock_receiver.sv */
// Downstream clock receiver model that measures high and low run lengths.
`timescale 1ns/1ps
`default_nettype none

module ops_clock_receiver (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Received clock.
  input  wire logic        pin,
  // Lengths of the last whole period, in synth cycles.
  output logic      [31:0] last_high,
  output logic      [31:0] last_low,
  output logic             period_done
);
  logic [31:0] high_cnt_ff;
  logic [31:0] low_cnt_ff;
  logic        prev_ff;

  // A period is closed by the rising edge that opens the next one, and the
  // first rise after reset only starts counting.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      high_cnt_ff <= '0;
      low_cnt_ff  <= '0;
      prev_ff     <= 1'b0;
      last_high   <= '0;
      last_low    <= '0;
      period_done <= 1'b0;
    end else begin
      prev_ff     <= pin;
      period_done <= 1'b0;
      if (pin && !prev_ff) begin
        last_high   <= high_cnt_ff;
        last_low    <= low_cnt_ff;
        period_done <= (high_cnt_ff != 0);
        high_cnt_ff <= 32'h0000_0001;
        low_cnt_ff  <= '0;
      end else if (pin) begin
        high_cnt_ff <= high_cnt_ff + 1;
      end else begin
        low_cnt_ff <= low_cnt_ff + 1;
      end
    end
  end
endmodule : ops_clock_receiver

`default_nettype wire

/* File: dv/tb.sv */
// Self-checking testbench for the output stage shaper.
`timescale 1ns/1ps
`default_nettype none

module tb;
  logic        CLOCK;
  logic        ARST_N;
  logic        PSEL;
  logic        PENABLE;
  logic        PWRITE;
  logic [7:0]  PADDR;
  logic [31:0] PWDATA;
  logic [31:0] PRDATA;
  logic        PREADY;
  logic        PSLVERR;
  logic [1:0]  TRUE_OUTPUT_PIN;
  logic [1:0]  COMPLEMENT_OUTPUT_PIN;
  logic [1:0]  SINGLE_ENDED;
  logic [3:0]  SWING_SELECT;
  logic [5:0]  COMMON_MODE_SELECT;
  logic [3:0]  IMPEDANCE_SELECT;
  logic [5:0]  SUPPLY_LEVEL_CODE;
  logic [31:0] rx_high;
  logic [31:0] rx_low;
  logic        rx_done;
  logic [31:0] rd;
  logic        err;
  logic [11:0] cfg;
  int          error_cnt = 0;
  int          checked = 0;
  int          seed = 52633;
  int          d;
  int          b;
  int          s;

  ops_shaper #(.NUM_BUF(2)) ops_shaper_inst (
    .CLOCK(CLOCK), .ARST_N(ARST_N), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .TRUE_OUTPUT_PIN(TRUE_OUTPUT_PIN),
    .COMPLEMENT_OUTPUT_PIN(COMPLEMENT_OUTPUT_PIN),
    .SINGLE_ENDED(SINGLE_ENDED), .SWING_SELECT(SWING_SELECT),
    .COMMON_MODE_SELECT(COMMON_MODE_SELECT),
    .IMPEDANCE_SELECT(IMPEDANCE_SELECT),
    .SUPPLY_LEVEL_CODE(SUPPLY_LEVEL_CODE));

  ops_clock_receiver ops_clock_receiver_inst (
    .clk(CLOCK), .rst_n(ARST_N), .pin(TRUE_OUTPUT_PIN[0]),
    .last_high(rx_high), .last_low(rx_low), .period_done(rx_done));

  initial begin
    CLOCK = 1'b0;
    forever #2 CLOCK = ~CLOCK;
  end

  task automatic tally_and_finish();
    if (error_cnt == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input int dat);
    int n;
    n = 0;
    @(posedge CLOCK);
    PSEL    <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE  <= w;
    PADDR   <= a;
    PWDATA  <= dat;
    @(posedge CLOCK);
    PENABLE <= 1'b1;
    do @(posedge CLOCK); while (PREADY !== 1'b1 && ++n < 100);
    chk("pready", 1, PREADY);
    rd = PRDATA;
    err = PSLVERR;
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
  endtask : apb

  function automatic int eh(int dv, int pul, int sh);
    int h;
    h = (pul == 0) ? dv - dv / 2 + (sh >>> 1) : pul;
    if (sh != 0 && h < 2) h = 2;
    return h;
  endfunction : eh

  function automatic int el(int dv, int pul, int sh);
    int l;
    l = (pul == 0) ? dv / 2 + sh - (sh >>> 1) : dv - pul + sh;
    if (sh != 0 && l < 2) l = 2;
    return l;
  endfunction : el

  task automatic wait_period();
    int n;
    n = 0;
    do @(posedge CLOCK); while (rx_done !== 1'b1 && ++n < 2000);
    chk("period end", 1, rx_done);
  endtask : wait_period

  task automatic run_case(input int dv, input int pul);
    apb(1'b1, ops_pkg::ADDR_PULSE_HIGH, 0);
    apb(1'b1, ops_pkg::ADDR_DIVIDE, dv);
    apb(1'b1, ops_pkg::ADDR_PULSE_HIGH, pul);
    repeat (3) wait_period();
    chk("high len", 32'(eh(dv, pul, 0)), rx_high);
    chk("low len", 32'(el(dv, pul, 0)), rx_low);
  endtask : run_case

  // Exactly one period in the next four carries the shift.
  task automatic shift_case(input int dv, input int pul, input int sh);
    int hits;
    hits = 0;
    apb(1'b1, ops_pkg::ADDR_EDGE_SHIFT, sh);
    repeat (4) begin
      wait_period();
      if (rx_high === 32'(eh(dv, pul, sh)) &&
          rx_low === 32'(el(dv, pul, sh))) hits++;
    end
    chk("shifted period", 1, 32'(hits));
  endtask : shift_case

  initial begin
    ARST_N  = 1'b0;
    PSEL    = 1'b0;
    PENABLE = 1'b0;
    PWRITE  = 1'b0;
    PADDR   = 8'h00;
    PWDATA  = 32'h0000_0000;
    repeat (20) @(posedge CLOCK);
    ARST_N <= 1'b1;
    apb(1'b0, ops_pkg::ADDR_DIVIDE, 0);
    chk("divide reset", ops_pkg::RST_DIVIDE, rd);
    apb(1'b0, ops_pkg::ADDR_PULSE_HIGH, 0);
    chk("pulse reset", ops_pkg::RST_PULSE_HIGH, rd);
    apb(1'b0, ops_pkg::ADDR_BUF_BASE + 8'h04, 0);
    chk("buffer reset", 32'(ops_pkg::RST_BUF_CFG), rd);
    apb(1'b1, 8'h40, 32'h0000_0001);
    apb(1'b0, 8'h40, 0);
    chk("unmapped error", 1, err);
    chk("unmapped data", 0, rd);
    chk("pins idle", 0, TRUE_OUTPUT_PIN);
    apb(1'b1, ops_pkg::ADDR_CONTROL, 1);
    run_case(4, 0);
    run_case(5, 0);
    repeat (6) begin
      d = 5 + {$random(seed)} % 30;
      run_case(d, 0);
      run_case(d, 1 + {$random(seed)} % (d - 1));
    end
    run_case(10, 0);
    shift_case(10, 0, 6);
    shift_case(10, 0, -20);
    shift_case(10, 0, 7);
    repeat (4) begin
      s = 1 + {$random(seed)} % 10;
      shift_case(10, 0, ($random(seed) & 1) ? -s : s);
    end
    run_case(12, 3);
    shift_case(12, 3, 5);
    shift_case(12, 3, -20);
    for (int i = 0; i < 8; i++) begin
      b = i % 2;
      cfg = 12'($random(seed));
      cfg[ops_pkg::BUF_SWING_LSB +: 2] = 2'(i);
      cfg[ops_pkg::BUF_CM_LSB +: 3] = 3'(i);
      apb(1'b1, ops_pkg::ADDR_BUF_BASE + 8'(4 * b), {20'h0_0000, cfg});
      repeat (2) @(posedge CLOCK);
      chk("single ended", cfg[0], SINGLE_ENDED[b]);
      chk("swing", cfg[3:2], SWING_SELECT[2*b +: 2]);
      chk("common mode", cfg[6:4], COMMON_MODE_SELECT[3*b +: 3]);
      chk("impedance", cfg[8:7], IMPEDANCE_SELECT[2*b +: 2]);
      chk("supply", cfg[11:9], SUPPLY_LEVEL_CODE[3*b +: 3]);
      repeat (12) begin
        @(posedge CLOCK);
        chk("copy", TRUE_OUTPUT_PIN[0], TRUE_OUTPUT_PIN[b]);
        chk("complement", cfg[0] ? TRUE_OUTPUT_PIN[b] ^ cfg[1] :
            !TRUE_OUTPUT_PIN[b], COMPLEMENT_OUTPUT_PIN[b]);
      end
    end
    apb(1'b1, ops_pkg::ADDR_CONTROL, 0);
    repeat (3) @(posedge CLOCK);
    chk("pins stopped", 0, TRUE_OUTPUT_PIN);
    tally_and_finish();
  end

  initial begin
    repeat (60000) @(posedge CLOCK);
    error_cnt++;
    tally_and_finish();
  end
endmodule : tb

`default_nettype wire
